// ==== rtl/scc_pkg.sv ====
// Constants, types and register map of the system clock controller
// Assumes one 100 MHz system clock; oscillator ticks and ready flags are synchronous to it
// Operation
// - Route chosen source to core and peripherals
// - Fast internal 16 MHz source selectable
// - Slow internal 128 kHz source selectable
// - External crystal 1 to 16 MHz selectable
// - Direct external clock up to 16 MHz
// - Reset default is fast source divided by eight
// - Software may change source and speed
// - Run-mode source change by register write
// - Keep old source until new one ready
// - Source changes never shorten a clock cycle
// - Core and each peripheral clock gated separately
// - Gate clocks as each low-power mode needs
// - Wakeup runs first from fast source /8
// - After stabilisation, restore source chosen before halt
// - Monitor watches external sources for lost activity
// - External failure falls back to fast /8
// - Configurable clock output pin
package scc_pkg;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int FAST_KHZ = 16000;
  localparam int SLOW_KHZ = 128;
  localparam int XTAL_MIN_KHZ = 1000;
  localparam int XTAL_MAX_KHZ = 16000;
  localparam int EXT_MAX_KHZ = 16000;
  localparam int STAB_NS = 2000;
  localparam int STAB_CYC = (STAB_NS * CLK_MHZ + 999) / 1000;
  localparam int MON_NS = 2000;
  localparam int MON_CYC = (MON_NS * CLK_MHZ + 999) / 1000;
  // ==========================================
  // Sizes and reset values
  localparam int PER_N = 8;
  localparam logic [2:0] DIV_RST = 3'h3;
  localparam logic [3:0] OSC_EN_RST = 4'h1;
  localparam logic [7:0] PER_EN_RST = 8'hFF;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] ADR_SRC = 8'h00;
  localparam logic [7:0] ADR_DIV = 8'h04;
  localparam logic [7:0] ADR_GATE = 8'h08;
  localparam logic [7:0] ADR_OUT = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_ST = 8'h14;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h18;
  // ==========================================
  // Field positions
  localparam int F_CORE = 0;
  localparam int F_PER = 8;
  localparam int F_MON_EN = 0;
  localparam int F_CO_EN = 1;
  localparam int F_CO_SEL = 2;
  localparam int F_CUR = 0;
  localparam int F_TGT = 2;
  localparam int F_BUSY = 4;
  localparam int F_HALT = 5;
  localparam int F_RDY = 8;
  localparam int IRQ_RDY = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_FAIL = 2;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0, SRC_SLOW = 2'h1, SRC_XTAL = 2'h2, SRC_EXT = 2'h3
  } scc_src_t;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1, ST_SWITCH = 4'h2, ST_HALT = 4'h4, ST_WAKE = 4'h8
  } scc_st_t;
  typedef struct packed {
    scc_st_t st;
    scc_src_t cur;
    scc_src_t tgt;
    logic [2:0] div_exp;
    logic [2:0] div_cfg;
    logic core_en;
    logic [PER_N-1:0] per_en;
    logic mon_en;
    logic co_en;
    logic [1:0] co_sel;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
    logic [7:0] stab;
    logic ack;
    logic [31:0] rdat;
    logic sys_tick;
    logic core_tick;
    logic [PER_N-1:0] per_tick;
    logic co_pin;
    logic irq;
    logic [3:0] osc_en;
  } scc_ctl_state_t;
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } scc_div_state_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic fail;
  } scc_mon_state_t;
endpackage

// ==== rtl/scc_link_if.sv ====
// Link between the controller and its divider and failure monitor
// Assumes all three sit on the same system clock
`timescale 1ns/100ps
interface scc_link_if;
  logic div_src_tick;
  logic [2:0] div_exp;
  logic div_restart;
  logic div_tick;
  logic mon_en;
  logic mon_tick;
  logic mon_fail;
  modport ctl (
    output div_src_tick, div_exp, div_restart, mon_en, mon_tick,
    input div_tick, mon_fail
  );
  modport div (input div_src_tick, div_exp, div_restart, output div_tick);
  modport mon (input mon_en, mon_tick, output mon_fail);
endinterface

// ==== rtl/scc_divider.sv ====
// Prescaler: one output tick per 2**div_exp ticks of the selected source
// Assumes source ticks are one-cycle pulses on the system clock
`timescale 1ns/100ps
module scc_divider (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Controller side
  scc_link_if.div lk
);
  scc_pkg::scc_div_state_t r_reg;
  scc_pkg::scc_div_state_t r_next;

  // ==========================================
  // Counter
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    // Restart drops the partial count so a new source starts a full cycle
    if (lk.div_restart) begin
      r_next.cnt = 7'h00;
    end else if (lk.div_src_tick) begin
      if (r_reg.cnt == ((7'h01 << lk.div_exp) - 7'h01)) begin
        r_next.cnt = 7'h00;
        r_next.tick = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign lk.div_tick = r_reg.tick;

  property p_div_restart;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      lk.div_restart |=> !lk.div_tick;
  endproperty
  a_div_restart: assert property (p_div_restart)
    else $error("divider ticked right after a restart");
endmodule

// ==== rtl/scc_fail_mon.sv ====
// Clock failure monitor: flags a source that stops ticking
// Assumes the watched tick is the active external source, on the system clock
`timescale 1ns/100ps
module scc_fail_mon (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Controller side
  scc_link_if.mon lk
);
  scc_pkg::scc_mon_state_t r_reg;
  scc_pkg::scc_mon_state_t r_next;

  // ==========================================
  // Silence counter
  always_comb begin
    r_next = r_reg;
    r_next.fail = 1'b0;
    if (!lk.mon_en || lk.mon_tick) begin
      r_next.cnt = 8'h00;
    end else if (r_reg.cnt == 8'(scc_pkg::MON_CYC - 1)) begin
      r_next.cnt = 8'h00;
      r_next.fail = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign lk.mon_fail = r_reg.fail;

  property p_mon_quiet;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      (lk.mon_en && lk.mon_tick) |=> !lk.mon_fail;
  endproperty
  a_mon_quiet: assert property (p_mon_quiet)
    else $error("failure flagged although the source ticked");
endmodule

// ==== rtl/scc_clk_ctrl.sv ====
// System clock controller top: source select, prescale, gating, failure fallback
// Assumes a classic Wishbone master and oscillator ticks synchronous to i_sys_clk
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
module scc_clk_ctrl (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Oscillators: fast, slow, crystal, direct
  input wire logic [3:0] i_osc_tick,
  input wire logic [3:0] i_osc_rdy,
  output logic [3:0] o_osc_en,
  // Power modes
  input wire logic i_halt_req,
  input wire logic i_wait_req,
  input wire logic i_wake,
  // Distributed clock enables
  output logic o_sys_tick,
  output logic o_core_tick,
  output logic [scc_pkg::PER_N-1:0] o_periph_tick,
  output logic o_clk_out_pin,
  // Status
  output logic [1:0] o_cur_src,
  output logic o_irq
);
  localparam int A_STAB_MAX = scc_pkg::STAB_CYC + 2;

  scc_link_if lk ();

  scc_divider u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .lk(lk)
  );

  scc_fail_mon u_mon (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .lk(lk)
  );

  scc_pkg::scc_ctl_state_t r_reg;
  scc_pkg::scc_ctl_state_t r_next;
  logic acc;
  logic wr;
  logic sw_req;
  logic restart;
  logic halted;
  logic tgt_rdy;
  logic src_tick;
  logic co_src;
  logic [2:0] ev;
  logic [2:0] clr;

  // ==========================================
  // Source mux and link drive
  // Fast, slow, crystal and direct clock each on one tick lane
  assign src_tick = i_osc_tick[r_reg.cur] && (r_reg.st != scc_pkg::ST_HALT);
  assign lk.div_src_tick = src_tick;
  assign lk.div_exp = r_reg.div_exp;
  assign lk.div_restart = restart;
  assign lk.mon_en = r_reg.mon_en && r_reg.cur[1] && (r_reg.st != scc_pkg::ST_HALT);
  assign lk.mon_tick = i_osc_tick[r_reg.cur];
  assign halted = (r_reg.st == scc_pkg::ST_HALT);
  assign tgt_rdy = i_osc_rdy[r_reg.tgt];

  // ==========================================
  // Next state
  always_comb begin
    r_next = r_reg;
    acc = i_wb_cyc && i_wb_stb && !r_reg.ack;
    wr = acc && i_wb_we;
    sw_req = 1'b0;
    restart = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    co_src = 1'b0;
    r_next.ack = acc;
    r_next.rdat = 32'h0;

    // Register writes
    if (wr && i_wb_sel[0]) begin
      unique case (i_wb_adr)
        scc_pkg::ADR_SRC: begin
          r_next.tgt = scc_pkg::scc_src_t'(i_wb_dat[1:0]);
          sw_req = 1'b1;
        end
        scc_pkg::ADR_DIV: begin
          r_next.div_cfg = i_wb_dat[2:0];
          sw_req = 1'b1;
        end
        scc_pkg::ADR_GATE: begin
          r_next.core_en = i_wb_dat[scc_pkg::F_CORE];
        end
        scc_pkg::ADR_OUT: begin
          r_next.mon_en = i_wb_dat[scc_pkg::F_MON_EN];
          r_next.co_en = i_wb_dat[scc_pkg::F_CO_EN];
          r_next.co_sel = i_wb_dat[scc_pkg::F_CO_SEL +: 2];
        end
        scc_pkg::ADR_IRQ_ST: begin
          clr = i_wb_dat[2:0];
        end
        scc_pkg::ADR_IRQ_MSK: begin
          r_next.irq_msk = i_wb_dat[2:0];
        end
        default: begin
        end
      endcase
    end
    if (wr && i_wb_sel[1] && (i_wb_adr == scc_pkg::ADR_GATE)) begin
      r_next.per_en = i_wb_dat[scc_pkg::F_PER +: scc_pkg::PER_N];
    end

    // Register reads; unmapped offsets read zero
    if (acc && !i_wb_we) begin
      unique case (i_wb_adr)
        scc_pkg::ADR_SRC: r_next.rdat[1:0] = r_reg.tgt;
        scc_pkg::ADR_DIV: r_next.rdat[2:0] = r_reg.div_cfg;
        scc_pkg::ADR_GATE: begin
          r_next.rdat[scc_pkg::F_CORE] = r_reg.core_en;
          r_next.rdat[scc_pkg::F_PER +: scc_pkg::PER_N] = r_reg.per_en;
        end
        scc_pkg::ADR_OUT: begin
          r_next.rdat[scc_pkg::F_MON_EN] = r_reg.mon_en;
          r_next.rdat[scc_pkg::F_CO_EN] = r_reg.co_en;
          r_next.rdat[scc_pkg::F_CO_SEL +: 2] = r_reg.co_sel;
        end
        scc_pkg::ADR_STAT: begin
          r_next.rdat[scc_pkg::F_CUR +: 2] = r_reg.cur;
          r_next.rdat[scc_pkg::F_TGT +: 2] = r_reg.tgt;
          r_next.rdat[scc_pkg::F_BUSY] = (r_reg.st != scc_pkg::ST_RUN);
          r_next.rdat[scc_pkg::F_HALT] = halted;
          r_next.rdat[scc_pkg::F_RDY +: 4] = i_osc_rdy;
        end
        scc_pkg::ADR_IRQ_ST: r_next.rdat[2:0] = r_reg.irq_st;
        scc_pkg::ADR_IRQ_MSK: r_next.rdat[2:0] = r_reg.irq_msk;
        default: r_next.rdat = 32'h0;
      endcase
    end

    // Mode sequencing
    unique case (r_reg.st)
      scc_pkg::ST_RUN: begin
        if (i_halt_req) begin
          r_next.st = scc_pkg::ST_HALT;
        end else if (sw_req) begin
          r_next.st = scc_pkg::ST_SWITCH;
        end
      end
      scc_pkg::ST_SWITCH: begin
        ev[scc_pkg::IRQ_RDY] = tgt_rdy;
        if (i_halt_req) begin
          r_next.st = scc_pkg::ST_HALT;
        end else if (tgt_rdy && lk.div_tick) begin
          // Old source keeps running until the new one is ready
          r_next.cur = r_reg.tgt;
          // Switch only on a finished output cycle, never mid-cycle
          r_next.div_exp = r_reg.div_cfg;
          restart = 1'b1;
          r_next.st = scc_pkg::ST_RUN;
          ev[scc_pkg::IRQ_DONE] = 1'b1;
        end
      end
      scc_pkg::ST_HALT: begin
        if (i_wake) begin
          r_next.cur = scc_pkg::SRC_FAST;
          r_next.div_exp = scc_pkg::DIV_RST;
          restart = 1'b1;
          r_next.stab = 8'(scc_pkg::STAB_CYC);
          r_next.st = scc_pkg::ST_WAKE;
        end
      end
      scc_pkg::ST_WAKE: begin
        if (r_reg.stab == 8'h00) begin
          // Selection kept through halt is resumed
          r_next.st = scc_pkg::ST_SWITCH;
        end else begin
          r_next.stab = r_reg.stab - 8'h01;
        end
      end
    endcase

    // Failure fallback overrides any pending switch
    if (lk.mon_fail) begin
      r_next.cur = scc_pkg::SRC_FAST;
      r_next.tgt = scc_pkg::SRC_FAST;
      r_next.div_exp = scc_pkg::DIV_RST;
      restart = 1'b1;
      r_next.st = scc_pkg::ST_RUN;
      ev[scc_pkg::IRQ_FAIL] = 1'b1;
    end

    // Sticky flags: a new event beats a same-cycle clear
    r_next.irq_st = (r_reg.irq_st & ~clr) | ev;
    r_next.irq = |(r_next.irq_st & r_next.irq_msk);

    // Gated clock enables
    r_next.sys_tick = lk.div_tick && !halted;
    r_next.core_tick = lk.div_tick && !halted && r_reg.core_en && !i_wait_req;
    r_next.per_tick = {scc_pkg::PER_N{lk.div_tick && !halted}} & r_reg.per_en;

    // Clock output pin: system, fast, slow or active source
    unique case (r_reg.co_sel)
      2'h0: co_src = lk.div_tick;
      2'h1: co_src = i_osc_tick[scc_pkg::SRC_FAST];
      2'h2: co_src = i_osc_tick[scc_pkg::SRC_SLOW];
      2'h3: co_src = i_osc_tick[r_reg.cur];
    endcase
    if (!r_reg.co_en) begin
      r_next.co_pin = 1'b0;
    end else if (co_src) begin
      r_next.co_pin = !r_reg.co_pin;
    end

    // Oscillators stay on only while in use; all off in halt
    if (r_next.st == scc_pkg::ST_HALT) begin
      r_next.osc_en = 4'h0;
    end else begin
      r_next.osc_en = (4'h1 << r_next.cur) | (4'h1 << r_next.tgt);
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.st <= scc_pkg::ST_RUN;
      r_reg.div_exp <= scc_pkg::DIV_RST;
      r_reg.div_cfg <= scc_pkg::DIV_RST;
      r_reg.core_en <= 1'b1;
      r_reg.per_en <= scc_pkg::PER_EN_RST;
      r_reg.osc_en <= scc_pkg::OSC_EN_RST;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs
  assign o_wb_dat = r_reg.rdat;
  assign o_wb_ack = r_reg.ack;
  assign o_osc_en = r_reg.osc_en;
  assign o_sys_tick = r_reg.sys_tick;
  assign o_core_tick = r_reg.core_tick;
  assign o_periph_tick = r_reg.per_tick;
  assign o_clk_out_pin = r_reg.co_pin;
  assign o_cur_src = r_reg.cur;
  assign o_irq = r_reg.irq;

  // ==========================================
  // Checks
  property p_reset_src;
    @(posedge i_sys_clk) disable iff (i_rst)
      $fell(i_rst) |-> (r_reg.cur == scc_pkg::SRC_FAST) && (r_reg.div_exp == 3'h3);
  endproperty
  a_reset_src: assert property (p_reset_src)
    else $error("reset did not select fast source divided by eight");

  property p_wait_ready;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      ($changed(r_reg.cur) && (r_reg.cur != scc_pkg::SRC_FAST))
        |-> (($past(i_osc_rdy) & (4'h1 << r_reg.cur)) != 4'h0);
  endproperty
  a_wait_ready: assert property (p_wait_ready)
    else $error("source switched before it was ready");

  property p_on_boundary;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      ($changed(r_reg.cur) && !$past(lk.mon_fail) && ($past(r_reg.st) == scc_pkg::ST_SWITCH))
        |-> $past(lk.div_tick);
  endproperty
  a_on_boundary: assert property (p_on_boundary)
    else $error("source switched in the middle of a clock cycle");

  property p_core_gate;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      (lk.div_tick && !halted && !r_reg.core_en) |=> (o_sys_tick && !o_core_tick);
  endproperty
  a_core_gate: assert property (p_core_gate)
    else $error("core clock ran while gated");

  property p_halt_gate;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      (halted && $past(halted)) |-> (o_periph_tick == 8'h00) && !o_core_tick && (o_osc_en == 4'h0);
  endproperty
  a_halt_gate: assert property (p_halt_gate)
    else $error("clocks running in halt");

  property p_wake_fast;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      (halted && i_wake && !lk.mon_fail)
        |=> (r_reg.cur == scc_pkg::SRC_FAST) && (r_reg.div_exp == 3'h3)
            && (r_reg.st == scc_pkg::ST_WAKE);
  endproperty
  a_wake_fast: assert property (p_wake_fast)
    else $error("wakeup did not start from fast source divided by eight");

  property p_wake_restore;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      $rose(r_reg.st == scc_pkg::ST_WAKE)
        |-> ##[1:A_STAB_MAX] (r_reg.st == scc_pkg::ST_SWITCH);
  endproperty
  a_wake_restore: assert property (p_wake_restore)
    else $error("no return to the chosen source after stabilisation");

  property p_fail_fallback;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      lk.mon_fail |=> (r_reg.cur == scc_pkg::SRC_FAST) && (r_reg.div_exp == 3'h3)
        && r_reg.irq_st[scc_pkg::IRQ_FAIL];
  endproperty
  a_fail_fallback: assert property (p_fail_fallback)
    else $error("clock failure did not fall back to fast source");

  property p_done_flag;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      ((r_reg.st == scc_pkg::ST_SWITCH) && tgt_rdy && lk.div_tick && !i_halt_req)
        |=> r_reg.irq_st[scc_pkg::IRQ_DONE]
            && (o_irq || !r_reg.irq_msk[scc_pkg::IRQ_DONE]);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("switch completion not flagged");

  property p_co_off;
    @(posedge i_sys_clk) disable iff (i_rst || !i_ce)
      !r_reg.co_en |=> !o_clk_out_pin;
  endproperty
  a_co_off: assert property (p_co_off)
    else $error("clock output pin moved while disabled");
endmodule

// ==== verification/scc_osc_model.sv ====
// Oscillator bank model: ready flags and one-cycle ticks for the four sources
// Assumes enables come from the controller and ticks live on the system clock
`timescale 1ns/100ps
module scc_osc_model #(
  parameter int P0 = 6,
  parameter int P1 = 781,
  parameter int P2 = 10,
  parameter int P3 = 7,
  parameter int RDY_DLY = 30
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Control
  input wire logic [3:0] i_en,
  input wire logic [3:0] i_stop,
  // Oscillator outputs
  output logic [3:0] o_tick = '0,
  output logic [3:0] o_rdy = '0
);
  // ==========================================
  // Start-up delay, then periodic ticks
  int cnt [4];
  int rc [4];
  function automatic int per(int k);
    case (k)
      0: return P0;
      1: return P1;
      2: return P2;
      default: return P3;
    endcase
  endfunction
  always @(posedge i_sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      // Disabled source loses ready at once, like a stopped oscillator
      if (i_rst || !i_en[k]) begin
        rc[k] <= 0;
        cnt[k] <= 0;
        o_rdy[k] <= 1'b0;
        o_tick[k] <= 1'b0;
      end else begin
        if (rc[k] < RDY_DLY) rc[k] <= rc[k] + 1;
        else o_rdy[k] <= 1'b1;
        if (o_rdy[k] && !i_stop[k]) begin
          cnt[k] <= (cnt[k] == per(k) - 1) ? 0 : cnt[k] + 1;
          o_tick[k] <= (cnt[k] == per(k) - 1);
        end else begin
          o_tick[k] <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench of the system clock controller
// Assumes the oscillator model on the far side and a Wishbone master task here
`timescale 1ns/100ps
module tb;
  // ==========================================
  // Signals
  logic clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0, stop = '0, tick, rdy, osc_en;
  logic [31:0] wdat = '0, rdat, q;
  logic ack, halt = 0, wreq = 0, wake = 0, sys_t, core_t, pin, irq;
  logic [7:0] per_t;
  logic [1:0] cur;
  int error_cnt = 0, total_checks = 0, cn, pn [8], n;
  logic [31:0] seed = 32'h4807;
  int per_of [4] = '{6, 781, 10, 7};
  initial forever #5 clk = ~clk;
  scc_clk_ctrl uut (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_osc_tick(tick), .i_osc_rdy(rdy), .o_osc_en(osc_en),
    .i_halt_req(halt), .i_wait_req(wreq), .i_wake(wake), .o_sys_tick(sys_t),
    .o_core_tick(core_t), .o_periph_tick(per_t), .o_clk_out_pin(pin), .o_cur_src(cur),
    .o_irq(irq));
  scc_osc_model osc (.i_sys_clk(clk), .i_rst(rst), .i_en(osc_en), .i_stop(stop),
    .o_tick(tick), .o_rdy(rdy));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_gap(int src, int e);
    return per_of[src] << e;
  endfunction
  // Settled run on one source: only that oscillator is enabled, hence ready
  function automatic logic [31:0] stat_exp(int s);
    logic [31:0] v;
    v = '0;
    v[scc_pkg::F_CUR +: 2] = 2'(s);
    v[scc_pkg::F_TGT +: 2] = 2'(s);
    v[scc_pkg::F_RDY + s] = 1'b1;
    return v;
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; holds everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) chk(32'h0, 32'h1);
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task automatic wait_src(input logic [1:0] s, input int lim);
    int i;
    for (i = 0; i < lim && cur !== s; i++) @(posedge clk);
    chk(cur, s);
  endtask
  // Gap between two system ticks; a runt or stretched cycle shows here
  task automatic gap(output int g);
    int i;
    for (i = 0; i < 9000 && sys_t !== 1'b1; i++) @(posedge clk);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (sys_t !== 1'b1 && g < 9000);
  endtask
  task automatic count(input int c);
    cn = 0;
    pn = '{default: 0};
    repeat (c) begin
      @(posedge clk);
      cn += (core_t === 1'b1);
      for (int k = 0; k < 8; k++) pn[k] += (per_t[k] === 1'b1);
    end
  endtask
  task automatic toggles(input int c, output int t);
    logic p;
    @(posedge clk);
    p = pin;
    t = 0;
    repeat (c) begin
      @(posedge clk);
      t += (pin !== p);
      p = pin;
    end
  endtask
  // ==========================================
  // Scenarios
  initial begin
    logic [7:0] m;
    int src [3];
    src = '{3, 1, 2};
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(cur, 2'h0);
    chk(osc_en, 4'h1);
    wb(0, scc_pkg::ADR_GATE, 0); chk(q, 32'hFF01);
    wb(0, scc_pkg::ADR_DIV, 0); chk(q, 32'h3);
    wb(0, 8'h1C, 0); chk(q, 32'h0);
    gap(n); chk(n, exp_gap(0, 3));
    m = 8'(rnd());
    wb(1, scc_pkg::ADR_IRQ_MSK, {29'h0, m[2:0]});
    wb(0, scc_pkg::ADR_IRQ_MSK, 0); chk(q, {29'h0, m[2:0]});
    foreach (src[j]) begin
      wb(1, scc_pkg::ADR_SRC, src[j]);
      chk(cur, (j == 0) ? 2'h0 : 2'(src[j-1]));
      wait_src(2'(src[j]), 8000);
      gap(n); gap(n); chk(n, exp_gap(src[j], 3));
      wb(0, scc_pkg::ADR_STAT, 0);
      chk(q, stat_exp(src[j]));
      wb(0, scc_pkg::ADR_IRQ_ST, 0);
      chk(q, 32'h3);
      wb(1, scc_pkg::ADR_IRQ_ST, 32'h7);
      wb(0, scc_pkg::ADR_IRQ_ST, 0); chk(q, 32'h0);
    end
    wb(1, scc_pkg::ADR_SRC, 2);
    wait_src(2'h2, 8000);
    n = rnd() % 4;
    wb(1, scc_pkg::ADR_DIV, n);
    gap(cn); gap(cn); gap(cn); chk(cn, exp_gap(2, n));
    wb(1, scc_pkg::ADR_DIV, 3);
    gap(n); gap(n);
    m = 8'(rnd());
    wb(1, scc_pkg::ADR_GATE, {16'h0, m, 8'h00});
    count(160); chk(cn, 0);
    for (int k = 0; k < 8; k++) chk(pn[k], m[k] ? 2 : 0);
    wb(1, scc_pkg::ADR_GATE, 32'hFF01);
    wreq <= 1;
    count(160); chk(cn, 0); chk(pn[0], 2);
    wreq <= 0;
    wb(1, scc_pkg::ADR_OUT, 32'hE);
    toggles(100, n);
    chk(n, 10);
    wb(1, scc_pkg::ADR_OUT, 32'h2);
    toggles(160, n);
    chk(n, 2);
    wb(1, scc_pkg::ADR_OUT, 32'h0); @(posedge clk); chk(pin, 1'b0);
    halt <= 1;
    repeat (3) @(posedge clk);
    halt <= 0;
    count(200); chk(pn[3], 0); chk(osc_en, 4'h0);
    wake <= 1; @(posedge clk); wake <= 0;
    repeat (2) @(posedge clk); chk(cur, 2'h0);
    wait_src(2'h2, 600);
    wb(1, scc_pkg::ADR_OUT, 32'h1);
    wb(1, scc_pkg::ADR_IRQ_ST, 32'h7);
    wb(1, scc_pkg::ADR_IRQ_MSK, 32'h4);
    chk(irq, 1'b0);
    stop <= 4'h4;
    wait_src(2'h0, 400);
    repeat (2) @(posedge clk); chk(irq, 1'b1);
    wb(0, scc_pkg::ADR_IRQ_ST, 0); chk(q[2], 1'b1);
    wb(1, scc_pkg::ADR_IRQ_ST, 32'h4);
    repeat (2) @(posedge clk); chk(irq, 1'b0);
    // Enable low freezes the divided clock; it resumes at its old rate
    gap(n);
    ce <= 0;
    count(100);
    chk(cn, 0);
    chk(pn[0], 0);
    ce <= 1;
    gap(n);
    chk(n, exp_gap(0, 3));
    final_report();
  end
  // Hang guard, sized well above the slow-source switches
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule
